/* hw/mba_pkg.sv */
package mba_pkg;

  // register byte offsets on the bus
  localparam logic [7:0]  OFF_X_START    = 8'h00;
  localparam logic [7:0]  OFF_X_END      = 8'h04;
  localparam logic [7:0]  OFF_Y_START    = 8'h08;
  localparam logic [7:0]  OFF_Y_END      = 8'h0C;
  localparam logic [7:0]  OFF_MODE_CTL   = 8'h10;
  localparam logic [7:0]  OFF_BITREV_CTL = 8'h14;
  localparam logic [7:0]  OFF_STATUS     = 8'h18;
  localparam logic [7:0]  OFF_LAST_EA    = 8'h1C;
  localparam logic [7:0]  OFF_COUNTS     = 8'h20;

  // field positions
  localparam int          X_SEL_LSB      = 0;
  localparam int          Y_SEL_LSB      = 4;
  localparam int          BR_SEL_LSB     = 8;
  localparam int          X_EN_BIT       = 15;
  localparam int          Y_EN_BIT       = 14;
  localparam int          BR_EN_BIT      = 15;
  localparam int          PIVOT_MSB      = 14;
  localparam logic [3:0]  SEL_OFF        = 4'hF;

  // reset values
  localparam logic [15:0] RST_ADDR       = 16'h0000;
  localparam logic [15:0] RST_MODE_CTL   = 16'h0FFF;
  localparam logic [15:0] RST_BITREV_CTL = 16'h0000;

  // addressing modes presented by the core
  localparam logic [1:0]  MODE_INDIRECT  = 2'h0;
  localparam logic [1:0]  MODE_POSTMOD   = 2'h1;
  localparam logic [1:0]  MODE_PREMOD    = 2'h2;
  localparam logic [1:0]  MODE_OFFSET    = 2'h3;

  typedef enum logic [3:0] {
    SL_IDLE   = 4'h1,
    SL_WRITE  = 4'h2,
    SL_RDWAIT = 4'h4,
    SL_RDDONE = 4'h8
  } mba_slv_state_t;

  function automatic logic [15:0] rev16(input logic [15:0] v);
    for (int i = 0; i < 16; i++) begin
      rev16[i] = v[15-i];
    end
  endfunction : rev16

endpackage : mba_pkg

/* hw/mba_ifs.sv */
interface mba_mod_if;
  logic [15:0] startAddr;
  logic [15:0] endAddr;
  logic [15:0] rawAddr;
  logic [15:0] fixedAddr;
  logic        active;
  logic        incrementing;
  logic        wordOnly;
  logic        corrected;
  modport unit (input startAddr, endAddr, rawAddr, active, incrementing, wordOnly,
                output fixedAddr, corrected);
  modport user (output startAddr, endAddr, rawAddr, active, incrementing, wordOnly,
                input fixedAddr, corrected);
endinterface : mba_mod_if

interface mba_bus_if;
  logic        wrEn;
  logic [7:0]  wrOff;
  logic [15:0] wrData;
  logic [7:0]  rdOff;
  logic [31:0] rdData;
  modport slave (output wrEn, wrOff, wrData, rdOff, input rdData);
  modport regs  (input wrEn, wrOff, wrData, rdOff, output rdData);
endinterface : mba_bus_if

/* hw/mba_modulo_unit.sv */
module mba_modulo_unit (
  mba_mod_if.unit m
);
  logic [16:0] bufLen;
  logic        over;
  logic        under;
  logic [16:0] wrapped;

  always_comb begin
    // length comes from the two bounds, up to 64 Kbytes
    bufLen  = {1'b0, m.endAddr} - {1'b0, m.startAddr} + 17'h00001;
    over    = m.incrementing && (m.rawAddr > m.endAddr);
    under   = !m.incrementing && (m.rawAddr < m.startAddr);
    wrapped = {1'b0, m.rawAddr};
    if (over) begin
      wrapped = {1'b0, m.rawAddr} - bufLen;
    end else if (under) begin
      wrapped = {1'b0, m.rawAddr} + bufLen;
    end
    m.corrected = m.active && (over || under);
    m.fixedAddr = m.active ? wrapped[15:0] : m.rawAddr;
    if (m.active && m.wordOnly) begin
      m.fixedAddr[0] = 1'b0;
    end
  end

endmodule : mba_modulo_unit

/* hw/mba_ahb_slave.sv */
module mba_ahb_slave (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  mba_bus_if.slave         bus
);
  typedef struct packed {
    mba_pkg::mba_slv_state_t st;
    logic [7:0]              off;
    logic [31:0]             rdata;
  } mba_slv_t;

  mba_slv_t r;
  mba_slv_t next_r;
  logic     take;

  always_comb begin
    next_r     = r;
    take       = hsel && htrans[1] && hready;
    bus.wrEn   = (r.st == mba_pkg::SL_WRITE);
    bus.wrOff  = r.off;
    bus.wrData = hwdata[15:0];
    bus.rdOff  = r.off;
    hreadyout  = (r.st != mba_pkg::SL_RDWAIT);
    hresp      = 1'b0;
    hrdata     = r.rdata;
    case (r.st)
      mba_pkg::SL_RDWAIT: begin
        // one wait state lets a preceding write settle before sampling
        next_r.rdata = bus.rdData;
        next_r.st    = mba_pkg::SL_RDDONE;
      end
      mba_pkg::SL_IDLE, mba_pkg::SL_WRITE, mba_pkg::SL_RDDONE: begin
        next_r.st = mba_pkg::SL_IDLE;
        if (take) begin
          next_r.off = {haddr[7:2], 2'h0};
          next_r.st  = hwrite ? mba_pkg::SL_WRITE : mba_pkg::SL_RDWAIT;
        end
      end
      default: begin
        next_r.st = mba_pkg::SL_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r <= '{st: mba_pkg::SL_IDLE, off: 8'h00, rdata: 32'h00000000};
    end else begin
      r <= next_r;
    end
  end

endmodule : mba_ahb_slave

/* hw/mba_agen_top.sv */
// Summary of operation
// - one circular buffer in X space, one in Y; X covers program pointers.
// - any-length buffers run both ways, checked at both bounds.
// - four 16-bit registers hold X and Y buffer start and end.
// - Y circular addresses are word aligned, bit zero cleared.
// - buffer length is end minus start plus one, at most 32K words.
// - X select of 15 turns circular off in both X units.
// - X circular needs select not 15 and control bit 15 set.
// - Y circular needs select not 15 and control bit 14 set.
// - incrementing checks upper bound, decrementing checks lower bound.
// - passing a bound corrects the address, not only reaching it.
// - corrected pointer written back only for pre or post modify.
// - bit reversal only in X unit and only for writes.
// - only the modifier is bit reversed, addresses stay normal.
// - bit reversal needs select not 15, enable set, pre/post increment.
// - fifteen-bit pivot supplies the increment, scaled to bytes.
// - other modes or byte size give normal addresses.
// - bit reversal adds pivot to pointer, ignores offset, clears bit zero.
// - bit reversal beats circular in X write unit; X reads stay circular.
// - reversed index is the normal index with mirrored bit order.
module mba_agen_top (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        reqValid,
  input  wire logic        reqSpaceY,
  input  wire logic        reqWrite,
  input  wire logic        reqByte,
  input  wire logic [1:0]  reqMode,
  input  wire logic [3:0]  reqPtrSel,
  input  wire logic [15:0] reqPtr,
  input  wire logic [15:0] reqOffset,
  output logic             eaValid,
  output logic [15:0]      eaAddr,
  output logic             wbValid,
  output logic [3:0]       wbPtrSel,
  output logic [15:0]      wbValue,
  output logic             circApplied,
  output logic             bitrevApplied
);
  typedef struct packed {
    logic [15:0] xStart;
    logic [15:0] xEnd;
    logic [15:0] yStart;
    logic [15:0] yEnd;
    logic [15:0] modeCtl;
    logic [15:0] brevCtl;
    logic        eaValid;
    logic [15:0] ea;
    logic        wbValid;
    logic [3:0]  wbSel;
    logic [15:0] wbValue;
    logic        circHit;
    logic        brevHit;
    logic        wrapHit;
    logic [15:0] wrapCount;
    logic [15:0] brevCount;
  } mba_top_t;

  mba_top_t  r;
  mba_top_t  next_r;

  mba_bus_if bus ();
  mba_mod_if modIf ();

  logic [3:0]  xSel;
  logic [3:0]  ySel;
  logic [3:0]  brSel;
  logic        xCircOn;
  logic        yCircOn;
  logic        brevOn;
  logic        isPre;
  logic        isPost;
  logic        positiveOffs;
  logic        incMode;
  logic        brevActive;
  logic        circActive;
  logic [15:0] rawAddr;
  logic [15:0] pivotBytes;
  logic [15:0] brevNext;
  logic [15:0] newPtr;
  logic [15:0] effAddr;

  // a select of 15 switches a unit off whatever its enable says
  function automatic logic sel_on(input logic [3:0] sel, input logic en);
    sel_on = (sel != mba_pkg::SEL_OFF) && en;
  endfunction : sel_on

  mba_ahb_slave u_slave (
    .clk       (clk),
    .rstn      (rstn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hrdata    (hrdata),
    .hresp     (hresp),
    .bus       (bus.slave)
  );

  mba_modulo_unit u_modulo (
    .m (modIf.unit)
  );

  // mode decode
  always_comb begin
    xSel         = r.modeCtl[mba_pkg::X_SEL_LSB +: 4];
    ySel         = r.modeCtl[mba_pkg::Y_SEL_LSB +: 4];
    brSel        = r.modeCtl[mba_pkg::BR_SEL_LSB +: 4];
    xCircOn      = sel_on(xSel, r.modeCtl[mba_pkg::X_EN_BIT]);
    yCircOn      = sel_on(ySel, r.modeCtl[mba_pkg::Y_EN_BIT]);
    brevOn       = sel_on(brSel, r.brevCtl[mba_pkg::BR_EN_BIT]);
    isPre        = (reqMode == mba_pkg::MODE_PREMOD);
    isPost       = (reqMode == mba_pkg::MODE_POSTMOD);
    positiveOffs = !reqOffset[15] && (reqOffset != 16'h0000);
    incMode      = (isPre || isPost) && positiveOffs;
    // X space only, writes only, words only
    brevActive   = brevOn && !reqSpaceY && reqWrite && !reqByte && incMode
                   && (reqPtrSel == brSel);
  end

  // circular path: single bound pair per space
  always_comb begin
    if (reqSpaceY) begin
      circActive = yCircOn && (reqPtrSel == ySel);
    end else begin
      // reversal owns the write unit; the read unit keeps circular
      circActive = xCircOn && (reqPtrSel == xSel) && !brevActive;
    end
    rawAddr = (reqMode == mba_pkg::MODE_INDIRECT) ? reqPtr : reqPtr + reqOffset;
    modIf.startAddr    = reqSpaceY ? r.yStart : r.xStart;
    modIf.endAddr      = reqSpaceY ? r.yEnd : r.xEnd;
    modIf.rawAddr      = rawAddr;
    modIf.active       = circActive && (reqMode != mba_pkg::MODE_INDIRECT);
    modIf.incrementing = !reqOffset[15];
    modIf.wordOnly     = reqSpaceY;
  end

  // bit-reversed path: carry runs from msb toward lsb
  always_comb begin
    pivotBytes = {r.brevCtl[mba_pkg::PIVOT_MSB:0], 1'b0};
    brevNext   = mba_pkg::rev16(mba_pkg::rev16(reqPtr) + mba_pkg::rev16(pivotBytes));
    brevNext[0] = 1'b0;
  end

  // effective address and pointer update
  always_comb begin
    newPtr  = reqPtr;
    effAddr = reqPtr;
    if (brevActive) begin
      // the mode's own offset is ignored here
      newPtr  = brevNext;
      effAddr = isPre ? brevNext : {reqPtr[15:1], 1'b0};
    end else begin
      case (reqMode)
        mba_pkg::MODE_PREMOD: begin
          newPtr  = modIf.fixedAddr;
          effAddr = modIf.fixedAddr;
        end
        mba_pkg::MODE_POSTMOD: begin
          newPtr  = modIf.fixedAddr;
          effAddr = reqPtr;
          if (modIf.active && modIf.wordOnly) begin
            // y circular data is word sized, so the address stays even
            effAddr[0] = 1'b0;
          end
        end
        mba_pkg::MODE_OFFSET: begin
          effAddr = modIf.fixedAddr;
        end
        default: begin
          effAddr = reqPtr;
        end
      endcase
    end
  end

  // register file, bus access and result capture
  always_comb begin
    next_r = r;
    if (bus.wrEn) begin
      case (bus.wrOff)
        mba_pkg::OFF_X_START:    next_r.xStart  = bus.wrData;
        mba_pkg::OFF_X_END:      next_r.xEnd    = bus.wrData;
        mba_pkg::OFF_Y_START:    next_r.yStart  = bus.wrData;
        mba_pkg::OFF_Y_END:      next_r.yEnd    = bus.wrData;
        mba_pkg::OFF_MODE_CTL:   next_r.modeCtl = bus.wrData;
        mba_pkg::OFF_BITREV_CTL: next_r.brevCtl = bus.wrData;
        default: begin
        end
      endcase
    end
    next_r.eaValid = reqValid;
    next_r.wbValid = reqValid && (isPre || isPost);
    if (reqValid) begin
      next_r.ea      = effAddr;
      next_r.wbSel   = reqPtrSel;
      next_r.wbValue = newPtr;
      next_r.circHit = modIf.active;
      next_r.brevHit = brevActive;
      next_r.wrapHit = modIf.corrected;
      if (modIf.corrected) begin
        next_r.wrapCount = r.wrapCount + 16'h0001;
      end
      if (brevActive) begin
        next_r.brevCount = r.brevCount + 16'h0001;
      end
    end
    // clearing the counters loses no event taken in the same cycle
    if (bus.wrEn && (bus.wrOff == mba_pkg::OFF_COUNTS)) begin
      next_r.wrapCount = (reqValid && modIf.corrected) ? 16'h0001 : 16'h0000;
      next_r.brevCount = (reqValid && brevActive) ? 16'h0001 : 16'h0000;
    end
  end

  always_comb begin
    case (bus.rdOff)
      mba_pkg::OFF_X_START:    bus.rdData = {16'h0000, r.xStart};
      mba_pkg::OFF_X_END:      bus.rdData = {16'h0000, r.xEnd};
      mba_pkg::OFF_Y_START:    bus.rdData = {16'h0000, r.yStart};
      mba_pkg::OFF_Y_END:      bus.rdData = {16'h0000, r.yEnd};
      mba_pkg::OFF_MODE_CTL:   bus.rdData = {16'h0000, r.modeCtl};
      mba_pkg::OFF_BITREV_CTL: bus.rdData = {16'h0000, r.brevCtl};
      mba_pkg::OFF_STATUS:     bus.rdData = {26'h0000000, brevOn, yCircOn, xCircOn,
                                             r.wrapHit, r.brevHit, r.circHit};
      mba_pkg::OFF_LAST_EA:    bus.rdData = {16'h0000, r.ea};
      mba_pkg::OFF_COUNTS:     bus.rdData = {r.brevCount, r.wrapCount};
      default:                 bus.rdData = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r.xStart    <= mba_pkg::RST_ADDR;
      r.xEnd      <= mba_pkg::RST_ADDR;
      r.yStart    <= mba_pkg::RST_ADDR;
      r.yEnd      <= mba_pkg::RST_ADDR;
      r.modeCtl   <= mba_pkg::RST_MODE_CTL;
      r.brevCtl   <= mba_pkg::RST_BITREV_CTL;
      r.eaValid   <= 1'b0;
      r.ea        <= 16'h0000;
      r.wbValid   <= 1'b0;
      r.wbSel     <= 4'h0;
      r.wbValue   <= 16'h0000;
      r.circHit   <= 1'b0;
      r.brevHit   <= 1'b0;
      r.wrapHit   <= 1'b0;
      r.wrapCount <= 16'h0000;
      r.brevCount <= 16'h0000;
    end else begin
      r <= next_r;
    end
  end

  assign eaValid       = r.eaValid;
  assign eaAddr        = r.ea;
  assign wbValid       = r.wbValid;
  assign wbPtrSel      = r.wbSel;
  assign wbValue       = r.wbValue;
  assign circApplied   = r.circHit;
  assign bitrevApplied = r.brevHit;

endmodule : mba_agen_top

/* dv/mba_agen_checker.sv */
module mba_agen_checker (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        hresp,
  input wire logic        reqValid,
  input wire logic        reqSpaceY,
  input wire logic        reqWrite,
  input wire logic        reqByte,
  input wire logic [1:0]  reqMode,
  input wire logic [3:0]  reqPtrSel,
  input wire logic [15:0] reqPtr,
  input wire logic        eaValid,
  input wire logic [15:0] eaAddr,
  input wire logic        wbValid,
  input wire logic [3:0]  wbPtrSel,
  input wire logic [15:0] wbValue,
  input wire logic        circApplied,
  input wire logic        bitrevApplied
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_mod_req;
    reqValid && (reqMode == mba_pkg::MODE_POSTMOD || reqMode == mba_pkg::MODE_PREMOD);
  endsequence
  sequence s_y_req;
    reqValid && reqSpaceY;
  endsequence
  sequence s_xpost_req;
    reqValid && !reqSpaceY && reqMode == mba_pkg::MODE_POSTMOD;
  endsequence
  a_ea_follows: assert property (reqValid |=> eaValid) else $error("ea valid missing");
  a_ea_lone: assert property (!reqValid |=> !eaValid) else $error("stray ea valid");
  a_wb_modify: assert property (s_mod_req |=> wbValid && wbPtrSel == $past(reqPtrSel))
    else $error("write back missing");
  a_wb_none: assert property (reqValid && reqMode[0] == reqMode[1] |=> !wbValid)
    else $error("write back in plain mode");
  a_pre_same: assert property (reqValid && reqMode == mba_pkg::MODE_PREMOD |=> wbValue == eaAddr)
    else $error("pre modify mismatch");
  a_y_align: assert property (s_y_req ##1 circApplied |-> !eaAddr[0])
    else $error("y address odd");
  a_brev_xwrite: assert property (eaValid && bitrevApplied |->
    $past(reqWrite && !reqSpaceY && !reqByte && reqMode inside {2'h1, 2'h2}))
    else $error("reversal outside x word write");
  a_brev_lsb: assert property (eaValid && bitrevApplied |-> !eaAddr[0])
    else $error("reversed address odd");
  a_post_ea: assert property (s_xpost_req ##1 !bitrevApplied |-> eaAddr == $past(reqPtr))
    else $error("post modify address wrong");
  a_ind_plain: assert property (reqValid && reqMode == mba_pkg::MODE_INDIRECT |=>
    eaAddr == $past(reqPtr) && !circApplied && !bitrevApplied)
    else $error("indirect address altered");
  a_resp_okay: assert property (hresp == 1'b0) else $error("response not okay");
endmodule : mba_agen_checker

bind mba_agen_top mba_agen_checker u_mba_agen_checker (.*);

/* dv/mba_core_model.sv */
module mba_core_model (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        setEn,
  input  wire logic [3:0]  setSel,
  input  wire logic [15:0] setVal,
  input  wire logic        wbValid,
  input  wire logic [3:0]  wbPtrSel,
  input  wire logic [15:0] wbValue,
  input  wire logic [3:0]  rdSel,
  output logic [15:0]      rdPtr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] wreg [16];
  // working registers, updated by pointer write back
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 16; i++) wreg[i] <= 16'h0000;
    end else if (wbValid) begin
      wreg[wbPtrSel] <= wbValue;
    end else if (setEn) begin
      wreg[setSel] <= setVal;
    end
  end
  assign rdPtr = wreg[rdSel];
endmodule : mba_core_model

/* dv/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [1:0] M_IN = mba_pkg::MODE_INDIRECT;
  localparam logic [1:0] M_PO = mba_pkg::MODE_POSTMOD;
  localparam logic [1:0] M_PR = mba_pkg::MODE_PREMOD;
  localparam logic [1:0] M_OF = mba_pkg::MODE_OFFSET;
  logic        clk = 0, rstn = 0, hsel = 0, hwrite = 0, reqValid = 0, setEn = 0;
  logic        reqSpaceY = 0, reqWrite = 0, reqByte = 0, wbf;
  logic        hready, hreadyout, hresp, eaValid, wbValid, circApplied, bitrevApplied;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [1:0]  htrans = '0, reqMode = '0;
  logic [2:0]  hsize = 3'h2;
  logic [3:0]  reqPtrSel = '0, setSel = '0, wbPtrSel;
  logic [15:0] reqOffset = '0, setVal = '0, reqPtr, eaAddr, wbValue, ea, wbv;
  int          fails = 0, tests_run = 0;
  assign hready = hreadyout;
  always #12.5 clk = ~clk;
  mba_agen_top u_mba_agen_top (.*);
  mba_core_model u_mba_core_model (.*, .rdSel(reqPtrSel), .rdPtr(reqPtr));

  task chk(input logic [31:0] exp, input logic [31:0] act);
    tests_run++;
    if (act !== exp) begin
      fails++;
      $display("[ERR] %0t expected %h got %h", $time, exp, act);
    end
  endtask : chk
  task stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  task wait_rdy;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask : wait_rdy
  task ahb(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
    wait_rdy;
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= {16'h0, d};
    wait_rdy;
  endtask : ahb
  task op(input logic [3:0] s, input logic y, w, b, input logic [1:0] m,
          input logic [15:0] p, off, input logic ld, input logic [15:0] e,
          input logic f, input logic [15:0] v);
    if (ld) begin
      @(posedge clk); setEn <= 1'b1; setSel <= s; setVal <= p;
    end
    @(posedge clk); setEn <= 1'b0; reqValid <= 1'b1; reqPtrSel <= s;
    reqSpaceY <= y; reqWrite <= w; reqByte <= b; reqMode <= m; reqOffset <= off;
    @(posedge clk); reqValid <= 1'b0;
    @(negedge clk); ea = eaAddr; wbf = wbValid; wbv = wbValue;
    chk({16'h0, e}, {16'h0, ea});
    chk({31'h0, f}, {31'h0, wbf});
    if (f) chk({16'h0, v}, {16'h0, wbv});
  endtask : op
  function automatic logic [3:0] mir(input logic [3:0] i);
    mir = {i[0], i[1], i[2], i[3]};
  endfunction : mir

  task test_regs;
    for (int i = 0; i < 6; i++) begin
      ahb(1'b0, 8'(i * 4), 16'h0);
      chk({16'h0, i == 4 ? mba_pkg::RST_MODE_CTL : i == 5 ? mba_pkg::RST_BITREV_CTL
           : mba_pkg::RST_ADDR}, rd);
    end
    ahb(1'b1, mba_pkg::OFF_X_END, 16'hA5C3);
    ahb(1'b0, mba_pkg::OFF_X_END, 16'h0);
    chk(32'h0000A5C3, rd);
    ahb(1'b1, 8'h3C, 16'hFFFF);
    ahb(1'b0, 8'h3C, 16'h0);
    chk(32'h00000000, rd);
    $display("test_regs done");
  endtask : test_regs
  task test_xcirc;
    ahb(1'b1, mba_pkg::OFF_X_START, 16'h1000);
    ahb(1'b1, mba_pkg::OFF_X_END, 16'h101F);
    ahb(1'b1, mba_pkg::OFF_MODE_CTL, 16'h8FF1);
    op(1, 0, 0, 0, M_PO, 16'h101E, 16'h0002, 1, 16'h101E, 1, 16'h1000);
    op(1, 0, 0, 0, M_PO, 16'h101C, 16'h0006, 1, 16'h101C, 1, 16'h1002);
    op(1, 0, 0, 0, M_PR, 16'h1000, 16'hFFFE, 1, 16'h101E, 1, 16'h101E);
    op(1, 0, 0, 0, M_OF, 16'h101E, 16'h0004, 1, 16'h1002, 0, 16'h0);
    op(2, 0, 0, 0, M_PR, 16'h101E, 16'h0002, 1, 16'h1020, 1, 16'h1020);
    ahb(1'b1, mba_pkg::OFF_MODE_CTL, 16'h8FFF);
    op(1, 0, 0, 0, M_PR, 16'h101E, 16'h0002, 1, 16'h1020, 1, 16'h1020);
    ahb(1'b1, mba_pkg::OFF_MODE_CTL, 16'h0FF1);
    op(1, 0, 0, 0, M_PR, 16'h101E, 16'h0002, 1, 16'h1020, 1, 16'h1020);
    $display("test_xcirc done");
  endtask : test_xcirc
  task test_ycirc;
    ahb(1'b1, mba_pkg::OFF_Y_START, 16'h2000);
    ahb(1'b1, mba_pkg::OFF_Y_END, 16'h203F);
    ahb(1'b1, mba_pkg::OFF_MODE_CTL, 16'h4F3F);
    op(3, 1, 0, 0, M_PR, 16'h203E, 16'h0002, 1, 16'h2000, 1, 16'h2000);
    op(3, 1, 0, 0, M_PR, 16'h2001, 16'h0002, 1, 16'h2002, 1, 16'h2002);
    op(3, 1, 0, 0, M_PO, 16'h2001, 16'h0002, 1, 16'h2000, 1, 16'h2002);
    op(3, 0, 0, 0, M_PR, 16'h203E, 16'h0002, 1, 16'h2040, 1, 16'h2040);
    ahb(1'b1, mba_pkg::OFF_MODE_CTL, 16'h4FFF);
    op(3, 1, 0, 0, M_PR, 16'h203E, 16'h0002, 1, 16'h2040, 1, 16'h2040);
    $display("test_ycirc done");
  endtask : test_ycirc
  task test_brev;
    ahb(1'b1, mba_pkg::OFF_BITREV_CTL, 16'h8008);
    ahb(1'b1, mba_pkg::OFF_MODE_CTL, 16'h05FF);
    // buffer start 0x0000 is aligned to its size
    for (int i = 0; i < 16; i++) begin
      op(5, 0, 1, 0, M_PO, 16'h0, 16'h0006, i == 0, {11'h0, mir(4'(i)), 1'b0}, 1,
         {11'h0, mir(4'(i + 1)), 1'b0});
    end
    op(5, 0, 1, 1, M_PO, 16'h0010, 16'h0006, 1, 16'h0010, 1, 16'h0016);
    op(5, 0, 0, 0, M_PO, 16'h0010, 16'h0006, 1, 16'h0010, 1, 16'h0016);
    op(5, 0, 1, 0, M_IN, 16'h0010, 16'h0006, 1, 16'h0010, 0, 16'h0);
    ahb(1'b1, mba_pkg::OFF_BITREV_CTL, 16'h0008);
    op(5, 0, 1, 0, M_PO, 16'h0010, 16'h0002, 1, 16'h0010, 1, 16'h0012);
    ahb(1'b1, mba_pkg::OFF_BITREV_CTL, 16'h8008);
    ahb(1'b1, mba_pkg::OFF_MODE_CTL, 16'h85F5);
    // idle cycles separate the control write from the reversed pointer use
    op(5, 0, 1, 0, M_PO, 16'h0000, 16'h0002, 1, 16'h0000, 1, 16'h0010);
    op(5, 0, 0, 0, M_PO, 16'h101E, 16'h0002, 1, 16'h101E, 1, 16'h1000);
    $display("test_brev done");
  endtask : test_brev
  task test_counts;
    // six corrections and seventeen reversed writes so far
    ahb(1'b0, mba_pkg::OFF_COUNTS, 16'h0);
    chk(32'h00110006, rd);
    ahb(1'b0, mba_pkg::OFF_STATUS, 16'h0);
    chk(32'h0000002D, rd);
    ahb(1'b0, mba_pkg::OFF_LAST_EA, 16'h0);
    chk(32'h0000101E, rd);
    ahb(1'b1, mba_pkg::OFF_COUNTS, 16'h0);
    ahb(1'b0, mba_pkg::OFF_COUNTS, 16'h0);
    chk(32'h00000000, rd);
    $display("test_counts done");
  endtask : test_counts

  initial begin
    #(25 * 6000);
    fails++;
    stop_test;
  end
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    test_regs;
    test_xcirc;
    test_ycirc;
    test_brev;
    test_counts;
    stop_test;
  end
endmodule : tb
